/* File: logic/port_guard_pkg.sv */
// shared constants and carrier types of the port status and access guard
package port_guard_pkg;

  // ------------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------------
  localparam int              ADDR_W       = 12;
  localparam logic [11:0]     STATUS_BASE  = 12'h0100;
  localparam logic [11:0]     STATUS_STEP  = 12'h0004;
  localparam logic [11:0]     GUARD_OFS    = 12'h0700;
  localparam logic [11:0]     EV_STAT_OFS  = 12'h0710;
  localparam logic [11:0]     EV_MASK_OFS  = 12'h0714;

  // ------------------------------------------------------------------
  // port state report field layout
  // ------------------------------------------------------------------
  localparam int STARTED_BIT  = 0;
  localparam int DONE_BIT     = 1;
  localparam int LINK_UP_BIT  = 4;
  localparam int LANE_DIR_BIT = 5;
  localparam int MODE_LSB     = 6;
  localparam int MODE_W       = 3;
  localparam int PART_LSB     = 10;
  localparam int PART_W       = 4;
  localparam int DEVICE_LSB   = 16;
  localparam int DEVICE_W     = 5;

  // lane direction codes
  localparam logic LANE_UPSTREAM   = 1'h0;
  localparam logic LANE_DOWNSTREAM = 1'h1;

  // operating mode codes
  localparam logic [2:0] MODE_DISABLED   = 3'h0;
  localparam logic [2:0] MODE_DOWNSTREAM = 3'h1;
  localparam logic [2:0] MODE_UPSTREAM   = 3'h2;
  localparam logic [2:0] MODE_UNATTACHED = 3'h5;

  // ------------------------------------------------------------------
  // guard, event summary and reset values
  // ------------------------------------------------------------------
  localparam int           GUARD_W        = 16;
  localparam int           DONE_EV_LSB    = 16;
  localparam logic [15:0]  GUARD_RESET    = 16'h0000;
  localparam logic [31:0]  MASK_RESET     = 32'h0000_0000;
  localparam logic [31:0]  WORD_ZERO      = 32'h0000_0000;
  localparam int           ACC_PORT_W     = 4;

  // effective port condition, as driven by the partition logic and phy
  typedef struct packed {
    logic       dl_up;
    logic       lane_direction;
    logic [2:0] mode;
    logic       partition_enabled;
    logic [3:0] partition_id;
    logic [4:0] downstream_device_number;
  } port_state_t;

  // one access to a port's global space address/data pair
  typedef struct packed {
    logic [3:0]  port;
    logic        sel_data;
    logic        write;
    logic        read;
    logic [31:0] wdata;
  } gs_access_t;

  // unguarded write to the data register, passed on to global space
  typedef struct packed {
    logic        valid;
    logic [3:0]  port;
    logic [31:0] addr;
    logic [31:0] data;
  } gs_request_t;

endpackage

/* File: logic/port_guard_regs.sv */
// port state report registers, global space guard and its access pairs
//
// How it works
// R01: link active bit 4 follows the data link layer up or down state.
// R02: bit 5 gives lane direction while up: 0 upstream, 1 downstream.
// R03: lane direction comes from the lanes, so crosslink can flip it.
// R04: bits 8:6 report mode: 0 off, 1 down, 2 up, 5 unattached.
// R05: reported mode is the mode in effect, not the requested one.
// R06: a port whose partition is disabled reports mode zero.
// R07: bits 13:10 report the attached partition for operational modes.
// R08: bits 20:16 report device number for downstream ports.
// R09: guard register holds one block bit per port in bits 15:0.
// R10: a guarded port's address and data pair reads zero, ignores writes.
// R11: write-one-to-clear flags mark mode change started and completed.
// R12: read-only status writes do nothing; reserved bits read zero.
`timescale 1ns/1ps
`default_nettype none

module port_guard_regs #(
  parameter int NUM_PORTS = 12
) (
  input  wire logic                        clock,
  input  wire logic                        rst,
  input  wire logic [11:0]                 bus_addr,
  input  wire logic [31:0]                 bus_wdata,
  input  wire logic                        bus_write,
  input  wire logic                        bus_read,
  output logic [31:0]                      bus_rdata,
  input  wire port_guard_pkg::port_state_t [NUM_PORTS-1:0] port_state,
  input  wire logic [NUM_PORTS-1:0]        mode_change_started,
  input  wire logic [NUM_PORTS-1:0]        mode_change_done,
  input  wire port_guard_pkg::gs_access_t  gs_access,
  output logic [31:0]                      gs_rdata,
  output port_guard_pkg::gs_request_t      gs_request,
  output logic [15:0]                      global_space_guard_out,
  output logic                             irq
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic [15:0]          global_space_guard;
  logic [15:0]          next_global_space_guard;
  logic [31:0]          ev_mask;
  logic [31:0]          next_ev_mask;
  logic [31:0]          next_bus_rdata;
  logic [31:0]          next_gs_rdata;
  port_guard_pkg::gs_request_t next_gs_request;
  logic [31:0]          global_space_address_reg [NUM_PORTS];
  logic [31:0]          global_space_data_reg    [NUM_PORTS];
  logic [31:0]          next_address_reg         [NUM_PORTS];
  logic [31:0]          next_data_reg            [NUM_PORTS];

  logic [31:0]          status_word [NUM_PORTS];
  logic [NUM_PORTS-1:0] started_flag;
  logic [NUM_PORTS-1:0] done_flag;
  logic [NUM_PORTS-1:0] status_hit;
  logic [NUM_PORTS-1:0] clear_started;
  logic [NUM_PORTS-1:0] clear_done;
  logic [31:0]          ev_status;
  logic                 ev_write;
  logic                 acc_valid_port;
  logic                 acc_blocked;

  // ------------------------------------------------------------------
  // per port status views
  // ------------------------------------------------------------------
  assign ev_write = bus_write && bus_addr == port_guard_pkg::EV_STAT_OFS;

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    assign status_hit[p] = bus_addr == 12'(port_guard_pkg::STATUS_BASE +
                             12'(p) * port_guard_pkg::STATUS_STEP);
    // both the port's own word and the summary word can clear a flag
    assign clear_started[p] = bus_write &&
      ((status_hit[p] && bus_wdata[port_guard_pkg::STARTED_BIT]) ||
       (ev_write && bus_wdata[p]));                                // [R11]
    assign clear_done[p] = bus_write &&
      ((status_hit[p] && bus_wdata[port_guard_pkg::DONE_BIT]) ||
       (ev_write && bus_wdata[port_guard_pkg::DONE_EV_LSB + p]));  // [R11]

    port_status_view u_view (
      .clock         (clock),
      .rst           (rst),
      .state         (port_state[p]),
      .started_pulse (mode_change_started[p]),
      .done_pulse    (mode_change_done[p]),
      .clear_started (clear_started[p]),
      .clear_done    (clear_done[p]),
      .status_word   (status_word[p]),
      .started_flag  (started_flag[p]),
      .done_flag     (done_flag[p])
    );                                                             // [R04]
  end

  // ------------------------------------------------------------------
  // event summary and interrupt
  // ------------------------------------------------------------------
  always_comb begin
    ev_status = port_guard_pkg::WORD_ZERO;
    for (int i = 0; i < NUM_PORTS; i++) begin
      ev_status[i] = started_flag[i];
      ev_status[port_guard_pkg::DONE_EV_LSB + i] = done_flag[i];
    end
  end

  assign irq = |(ev_status & ev_mask);
  assign global_space_guard_out = global_space_guard;

  // ------------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------------
  always_comb begin
    next_global_space_guard = global_space_guard;
    next_ev_mask            = ev_mask;
    next_bus_rdata          = port_guard_pkg::WORD_ZERO;
    if (bus_write && bus_addr == port_guard_pkg::GUARD_OFS) begin
      next_global_space_guard = bus_wdata[15:0];                   // [R09]
    end
    if (bus_write && bus_addr == port_guard_pkg::EV_MASK_OFS) begin
      next_ev_mask = bus_wdata;
    end
    // writes to status words touch only the two flags: other bits drop
    if (bus_read) begin
      if (bus_addr == port_guard_pkg::GUARD_OFS) begin
        next_bus_rdata = {16'h0000, global_space_guard};           // [R09]
      end else if (bus_addr == port_guard_pkg::EV_STAT_OFS) begin
        next_bus_rdata = ev_status;
      end else if (bus_addr == port_guard_pkg::EV_MASK_OFS) begin
        next_bus_rdata = ev_mask;
      end else begin
        for (int i = 0; i < NUM_PORTS; i++) begin
          if (status_hit[i]) begin
            next_bus_rdata = status_word[i];                       // [R12]
          end
        end
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      global_space_guard <= port_guard_pkg::GUARD_RESET;
      ev_mask            <= port_guard_pkg::MASK_RESET;
      bus_rdata          <= port_guard_pkg::WORD_ZERO;
    end else begin
      global_space_guard <= next_global_space_guard;
      ev_mask            <= next_ev_mask;
      bus_rdata          <= next_bus_rdata;
    end
  end

  // ------------------------------------------------------------------
  // per port global space address/data pair
  // ------------------------------------------------------------------
  assign acc_valid_port = 32'(gs_access.port) < NUM_PORTS;
  assign acc_blocked = global_space_guard[gs_access.port];        // [R10]

  always_comb begin
    next_gs_rdata   = port_guard_pkg::WORD_ZERO;
    next_gs_request = '0;
    for (int i = 0; i < NUM_PORTS; i++) begin
      // a guarded pair is forced to zero so nothing leaks when unguarded
      if (global_space_guard[i]) begin
        next_address_reg[i] = port_guard_pkg::WORD_ZERO;          // [R10]
        next_data_reg[i]    = port_guard_pkg::WORD_ZERO;          // [R10]
      end else begin
        next_address_reg[i] = global_space_address_reg[i];
        next_data_reg[i]    = global_space_data_reg[i];
      end
    end
    if (acc_valid_port && !acc_blocked) begin
      if (gs_access.write && !gs_access.sel_data) begin
        next_address_reg[gs_access.port] = gs_access.wdata;
      end
      if (gs_access.write && gs_access.sel_data) begin
        next_data_reg[gs_access.port] = gs_access.wdata;
        next_gs_request.valid = 1'b1;
        next_gs_request.port  = gs_access.port;
        next_gs_request.addr  = global_space_address_reg[gs_access.port];
        next_gs_request.data  = gs_access.wdata;
      end
      if (gs_access.read) begin
        next_gs_rdata = gs_access.sel_data
                        ? global_space_data_reg[gs_access.port]
                        : global_space_address_reg[gs_access.port];
      end
    end                                                            // [R10]
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gs_rdata   <= port_guard_pkg::WORD_ZERO;
      gs_request <= '0;
      for (int i = 0; i < NUM_PORTS; i++) begin
        global_space_address_reg[i] <= port_guard_pkg::WORD_ZERO;
        global_space_data_reg[i]    <= port_guard_pkg::WORD_ZERO;
      end
    end else begin
      gs_rdata   <= next_gs_rdata;
      gs_request <= next_gs_request;
      for (int i = 0; i < NUM_PORTS; i++) begin
        global_space_address_reg[i] <= next_address_reg[i];
        global_space_data_reg[i]    <= next_data_reg[i];
      end
    end
  end

endmodule // port_guard_regs

`default_nettype wire

/* File: logic/port_status_view.sv */
// one port's state report word with its two mode change flags
`timescale 1ns/1ps
`default_nettype none

module port_status_view (
  input  wire logic                        clock,
  input  wire logic                        rst,
  input  wire port_guard_pkg::port_state_t state,
  input  wire logic                        started_pulse,
  input  wire logic                        done_pulse,
  input  wire logic                        clear_started,
  input  wire logic                        clear_done,
  output logic [31:0]                      status_word,
  output logic                             started_flag,
  output logic                             done_flag
);

  logic        link_active_flag;
  logic        lane_direction;
  logic [2:0]  mode;
  logic [3:0]  partition_id;
  logic [4:0]  downstream_device_number;
  logic        next_link_active_flag;
  logic        next_lane_direction;
  logic [2:0]  next_mode;
  logic [3:0]  next_partition_id;
  logic [4:0]  next_downstream_device_number;
  logic        next_started_flag;
  logic        next_done_flag;

  // ------------------------------------------------------------------
  // next values
  // ------------------------------------------------------------------
  always_comb begin
    next_link_active_flag = state.dl_up;                           // [R01]
    // the phy may swap an unattached port to downstream on crosslink,
    // so direction is taken from the lanes and never from the mode
    next_lane_direction = state.dl_up ? state.lane_direction // [R02] [R03]
                                      : port_guard_pkg::LANE_UPSTREAM;
    // mode in effect, not the requested control value
    next_mode = state.partition_enabled ? state.mode         // [R05] [R06]
                                        : port_guard_pkg::MODE_DISABLED;
    if (next_mode == port_guard_pkg::MODE_DOWNSTREAM ||
        next_mode == port_guard_pkg::MODE_UPSTREAM) begin
      next_partition_id = state.partition_id;                      // [R07]
    end else begin
      next_partition_id = 4'h0;
    end
    if (next_mode == port_guard_pkg::MODE_DOWNSTREAM) begin
      next_downstream_device_number = state.downstream_device_number; // [R08]
    end else begin
      next_downstream_device_number = 5'h00;
    end
    // a new event outruns a clear in the same cycle
    next_started_flag = started_pulse |
                        (started_flag & ~clear_started);    // [R11]
    next_done_flag    = done_pulse | (done_flag & ~clear_done); // [R11]
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      link_active_flag         <= 1'b0;
      lane_direction           <= port_guard_pkg::LANE_UPSTREAM;
      mode                     <= port_guard_pkg::MODE_DISABLED;
      partition_id             <= 4'h0;
      downstream_device_number <= 5'h00;
      started_flag             <= 1'b0;
      done_flag                <= 1'b0;
    end else begin
      link_active_flag         <= next_link_active_flag;
      lane_direction           <= next_lane_direction;
      mode                     <= next_mode;
      partition_id             <= next_partition_id;
      downstream_device_number <= next_downstream_device_number;
      started_flag             <= next_started_flag;
      done_flag                <= next_done_flag;
    end
  end

  // reserved bits are constant zero
  always_comb begin
    status_word = port_guard_pkg::WORD_ZERO;                       // [R12]
    status_word[port_guard_pkg::STARTED_BIT]  = started_flag;
    status_word[port_guard_pkg::DONE_BIT]     = done_flag;
    status_word[port_guard_pkg::LINK_UP_BIT]  = link_active_flag;
    status_word[port_guard_pkg::LANE_DIR_BIT] = lane_direction;
    status_word[port_guard_pkg::MODE_LSB +: port_guard_pkg::MODE_W] = mode;
    status_word[port_guard_pkg::PART_LSB +: port_guard_pkg::PART_W] =
      partition_id;
    status_word[port_guard_pkg::DEVICE_LSB +: port_guard_pkg::DEVICE_W] =
      downstream_device_number;
  end

endmodule // port_status_view

`default_nettype wire

/* File: test/port_guard_monitor.sv */
// assertion checker for the port state report and global space guard
`timescale 1ns/1ps
`default_nettype none

module port_guard_monitor #(
  parameter int NUM_PORTS = 12
) (
  input wire logic                                    clock,
  input wire logic                                    rst,
  input wire logic [11:0]                             bus_addr,
  input wire logic [31:0]                             bus_wdata,
  input wire logic                                    bus_write,
  input wire logic                                    bus_read,
  input wire logic [31:0]                             bus_rdata,
  input wire port_guard_pkg::port_state_t [NUM_PORTS-1:0] port_state,
  input wire logic [NUM_PORTS-1:0]                    mode_change_started,
  input wire port_guard_pkg::gs_access_t              gs_access,
  input wire logic [31:0]                             gs_rdata,
  input wire port_guard_pkg::gs_request_t             gs_request,
  input wire logic [15:0]                             global_space_guard_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // --------------------------------------------------------------
  // expected fields of port 0, undefined fields taken as zero
  // --------------------------------------------------------------
  logic [2:0]  em;
  logic [8:0]  eplace;
  logic        gp;
  logic        gsg;
  assign em = port_state[0].partition_enabled ? port_state[0].mode : 3'h0;
  assign eplace = {(em == 3'h1) ? port_state[0].downstream_device_number
                                : 5'h00,
                   (em == 3'h1 || em == 3'h2) ? port_state[0].partition_id
                                              : 4'h0};
  assign gp  = gs_access.port < NUM_PORTS;
  assign gsg = gp && global_space_guard_out[gs_access.port];

  sequence s_rd0;
    bus_read && bus_addr == port_guard_pkg::STATUS_BASE;
  endsequence
  sequence s_rd0_steady;
    s_rd0 ##0 $stable(port_state[0]);
  endsequence

  property p_link;
    s_rd0_steady |=> bus_rdata[4] == $past(port_state[0].dl_up);
  endproperty
  property p_dir;
    s_rd0_steady |=> bus_rdata[5] ==
      ($past(port_state[0].dl_up) & $past(port_state[0].lane_direction));
  endproperty
  property p_mode;
    s_rd0_steady |=> bus_rdata[8:6] == $past(em);
  endproperty
  property p_place;
    s_rd0_steady |=> {bus_rdata[20:16], bus_rdata[13:10]} == $past(eplace);
  endproperty
  property p_rsvd;
    s_rd0 |=> (bus_rdata & 32'hFFE0_C20C) == 32'h0000_0000;
  endproperty
  property p_flag;
    mode_change_started[0] ##1 !bus_write ##1 s_rd0 |=> bus_rdata[0];
  endproperty
  property p_guard_wr;
    bus_write && bus_addr == port_guard_pkg::GUARD_OFS |=>
      global_space_guard_out == $past(bus_wdata[15:0]);
  endproperty
  property p_guard_rd;
    bus_read && bus_addr == port_guard_pkg::GUARD_OFS |=>
      bus_rdata == {16'h0000, global_space_guard_out};
  endproperty
  property p_gs_block;
    gsg && (gs_access.read || gs_access.write) |=>
      gs_rdata == 32'h0000_0000 && !gs_request.valid;
  endproperty
  property p_gs_req;
    gp && !gsg && gs_access.write && gs_access.sel_data |=>
      gs_request.valid && gs_request.data == $past(gs_access.wdata);
  endproperty

  a_link: assert property (p_link) else $error("link bit wrong");
  a_dir: assert property (p_dir) else $error("lane bit wrong");
  a_mode: assert property (p_mode) else $error("mode");
  a_place: assert property (p_place) else $error("place wrong");
  a_rsvd: assert property (p_rsvd) else $error("reserved set");
  a_flag: assert property (p_flag) else $error("flag not set");
  a_guard_wr: assert property (p_guard_wr) else $error("guard wr");
  a_guard_rd: assert property (p_guard_rd) else $error("guard rd");
  a_gs_block: assert property (p_gs_block) else $error("not blocked");
  a_gs_req: assert property (p_gs_req) else $error("no request");
endmodule // port_guard_monitor

bind port_guard_regs port_guard_monitor #(.NUM_PORTS(NUM_PORTS)) u_mon (
  .clock(clock), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
  .port_state(port_state), .mode_change_started(mode_change_started),
  .gs_access(gs_access), .gs_rdata(gs_rdata), .gs_request(gs_request),
  .global_space_guard_out(global_space_guard_out));
`default_nettype wire

/* File: test/port_guard_regs_tb.sv */
// testbench for the port state report and global space guard
`timescale 1ns/1ps
`default_nettype none

module port_guard_regs_tb;
  logic                               clock = 1'b0;
  logic                               rst = 1'b1;
  logic [11:0]                        bus_addr = 12'h000;
  logic [31:0]                        bus_wdata = 32'h0000_0000;
  logic                               bus_write = 1'b0;
  logic                               bus_read = 1'b0;
  logic [31:0]                        bus_rdata;
  logic [31:0]                        gs_rdata;
  logic [31:0]                        d;
  logic                               irq;
  logic [15:0]                        guard;
  logic [11:0]                        st = 12'h000;
  logic [11:0]                        dn = 12'h000;
  port_guard_pkg::port_state_t [11:0] ps = '0;
  port_guard_pkg::gs_access_t         gsa = '0;
  port_guard_pkg::gs_request_t        req;
  int                                 errors = 0;
  int                                 n_checks = 0;

  always #50 clock = ~clock;

  port_guard_regs #(.NUM_PORTS(12)) uut (
    .clock(clock), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
    .port_state(ps), .mode_change_started(st), .mode_change_done(dn),
    .gs_access(gsa), .gs_rdata(gs_rdata), .gs_request(req),
    .global_space_guard_out(guard), .irq(irq));

  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clock);
    bus_addr <= a;
    bus_wdata <= v;
    bus_write <= 1'b1;
    @(posedge clock);
    bus_write <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge clock);
    bus_addr <= a;
    bus_read <= 1'b1;
    @(posedge clock);
    bus_read <= 1'b0;
    #1 v = bus_rdata;
  endtask
  // results of the access are settled when this returns
  task automatic gs(input logic [3:0] p, input logic sd, input logic w,
                    input logic [31:0] v);
    @(posedge clock);
    gsa <= '{port: p, sel_data: sd, write: w, read: !w, wdata: v};
    @(posedge clock);
    gsa.write <= 1'b0;
    gsa.read <= 1'b0;
    #1;
  endtask
  // undefined fields are expected as zero
  function automatic logic [31:0] exp_w(port_guard_pkg::port_state_t s);
    logic [2:0]  m;
    logic [31:0] w;
    m = s.partition_enabled ? s.mode : 3'h0;
    w = 32'h0000_0000;
    w[4] = s.dl_up;
    w[5] = s.dl_up & s.lane_direction;
    w[8:6] = m;
    if (m == 3'h1 || m == 3'h2) w[13:10] = s.partition_id;
    if (m == 3'h1) w[20:16] = s.downstream_device_number;
    return w;
  endfunction

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_reset;
    rd(12'h700, d);
    chk(d, 32'h0000_0000);
    rd(12'h714, d);
    chk(d, 32'h0000_0000);
    rd(12'h100, d);
    chk(d, 32'h0000_0000);
  endtask
  task automatic t_status;
    logic [2:0] modes [4] = '{3'h0, 3'h1, 3'h2, 3'h5};
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      ps[i] <= '{dl_up: i[0], lane_direction: i[1], mode: modes[i%4],
                 partition_enabled: i != 6, partition_id: 4'(i + 9),
                 downstream_device_number: 5'(i + 20)};
      repeat (3) @(posedge clock);
      rd(12'h100 + 12'(4 * i), d);
      chk(d, exp_w(ps[i]));
    end
  endtask
  task automatic t_cross;
    @(posedge clock);
    ps[0] <= '{1'b1, 1'b0, 3'h5, 1'b1, 4'h3, 5'h07};
    repeat (3) @(posedge clock);
    rd(12'h100, d);
    chk(d, exp_w(ps[0]));
    @(posedge clock);
    ps[0].lane_direction <= 1'b1;
    repeat (3) @(posedge clock);
    rd(12'h100, d);
    chk(32'(d[5]), 32'h0000_0001);
    wr(12'h100, 32'hFFFF_FFFF);
    rd(12'h100, d);
    chk(d, exp_w(ps[0]));
  endtask
  task automatic t_flags;
    @(posedge clock);
    st[0] <= 1'b1;
    dn[3] <= 1'b1;
    @(posedge clock);
    st <= 12'h000;
    dn <= 12'h000;
    rd(12'h100, d);
    chk(32'(d[1:0]), 32'h0000_0001);
    rd(12'h10C, d);
    chk(32'(d[1:0]), 32'h0000_0002);
    rd(12'h710, d);
    chk(d, 32'h0008_0001);
    chk(32'(irq), 32'h0000_0000);
    wr(12'h714, 32'h0000_0001);
    chk(32'(irq), 32'h0000_0001);
    wr(12'h710, 32'h0000_0001);
    chk(32'(irq), 32'h0000_0000);
    wr(12'h10C, 32'h0000_0002);
    rd(12'h100, d);
    chk(32'(d[1:0]), 32'h0000_0000);
    rd(12'h710, d);
    chk(d, 32'h0000_0000);
  endtask
  task automatic t_guard;
    gs(4'h2, 1'b0, 1'b1, 32'hA5A5_0010);
    gs(4'h2, 1'b1, 1'b1, 32'h1234_5678);
    chk({req.port, req.valid}, 32'h0000_0005);
    chk(req.addr, 32'hA5A5_0010);
    chk(req.data, 32'h1234_5678);
    gs(4'h2, 1'b0, 1'b0, 32'h0000_0000);
    chk(gs_rdata, 32'hA5A5_0010);
    wr(12'h700, 32'hFFFF_0004);
    chk(32'(guard), 32'h0000_0004);
    rd(12'h700, d);
    chk(d, 32'h0000_0004);
    gs(4'h2, 1'b0, 1'b0, 32'h0000_0000);
    chk(gs_rdata, 32'h0000_0000);
    gs(4'h2, 1'b1, 1'b1, 32'h0000_0055);
    chk(32'(req.valid), 32'h0000_0000);
    gs(4'h5, 1'b1, 1'b1, 32'h0000_0066);
    chk(32'(req.valid), 32'h0000_0001);
    wr(12'h700, 32'h0000_0000);
    gs(4'h2, 1'b0, 1'b0, 32'h0000_0000);
    chk(gs_rdata, 32'h0000_0000);
    rd(12'h7FC, d);
    chk(d, 32'h0000_0000);
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    t_reset;
    t_status;
    t_cross;
    t_flags;
    t_guard;
    stop_test;
  end
  // the tests need well under a thousand cycles
  initial begin
    #1_000_000;
    errors++;
    stop_test;
  end
endmodule // port_guard_regs_tb
`default_nettype wire
